// >>> design/sisf_pkg.sv
// shared constants and types for the serial line framer
package sisf_pkg;

	// =========================================================
	// character layout
	// =========================================================
	localparam int unsigned      CHAR_W      = 8;
	localparam int unsigned      SH_W        = 9;
	localparam logic [3:0]       LEN_BASE    = 4'h5;
	localparam logic [7:0]       MASK_FULL   = 8'hFF;
	localparam logic             LINE_MARK   = 1'h1;
	localparam logic             LINE_SPACE  = 1'h0;

	// =========================================================
	// bit timing in link clock ticks
	// =========================================================
	localparam logic [4:0]       ASYNC_LAST  = 5'h0F;
	localparam logic [4:0]       START_MID   = 5'h07;
	localparam logic [4:0]       STOP1_LAST  = 5'h0F;
	localparam logic [4:0]       STOP142_LAST = 5'h16;
	localparam logic [4:0]       STOP2_LAST  = 5'h1F;
	localparam logic [4:0]       ISO_STOP1_LAST = 5'h00;
	localparam logic [4:0]       ISO_STOP2_LAST = 5'h01;
	localparam logic [1:0]       SYNC_LEAD   = 2'h2;

	// =========================================================
	// buffering
	// =========================================================
	localparam int unsigned      FIFO_DEPTH  = 8;

	// =========================================================
	// types
	// =========================================================
	typedef enum logic [1:0] {MODE_ASYNC, MODE_ISO, MODE_SYNC} sisf_mode_type;
	typedef enum logic [1:0] {STOP_ONE, STOP_ONE_42, STOP_TWO} sisf_stop_type;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sisf_tx_state_type;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_HUNT,
		RX_LOCK} sisf_rx_state_type;

	typedef struct packed {
		sisf_mode_type mode;       // framing technique
		logic [1:0]    len_code;   // 0..3 selects 5..8 data bits
		sisf_stop_type stop;       // stop interval
		logic          par_en;     // append parity bit
		logic          par_odd;    // odd parity when set
		logic [7:0]    sync_char;  // sync pattern, low bits used
	} sisf_cfg_type;

	typedef struct packed {
		logic [7:0] data;          // received character, right aligned
		logic       err;           // framing or parity fault
	} sisf_rx_char_type;

endpackage : sisf_pkg

// >>> design/sisf_fifo.sv
// single clock word fifo with valid/ready on both sides
`timescale 1ns/1ps
module sisf_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk,        // system clock
	input  wire logic             rst,        // async reset, active high
	input  wire logic             in_valid,   // write request
	output logic                  in_ready,   // not full
	input  wire logic [WIDTH-1:0] in_data,    // write word
	output logic                  out_valid,  // not empty
	input  wire logic             out_ready,  // read request
	output logic [WIDTH-1:0]      out_data    // head word
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]      cnt_r, cnt_nxt;
	logic             wr, rd;

	// =========================================================
	// pointers and count
	// =========================================================
	always_comb begin
		in_ready  = (cnt_r != (AW+1)'(DEPTH));
		out_valid = (cnt_r != '0);
		out_data  = mem_r[rp_r];
		wr        = in_valid && in_ready;
		rd        = out_valid && out_ready;
		wp_nxt    = wr ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
		rp_nxt    = rd ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
		cnt_nxt   = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (wr) begin
			mem_r[wp_r] <= in_data;
		end
	end

endmodule : sisf_fifo

// >>> design/sisf_framer.sv
// serial line framer: async, isochronous and sync framing on a modem bit clock
`timescale 1ns/1ps
module sisf_framer (
	input  wire logic                      clk,       // system clock
	input  wire logic                      rst,       // async reset, active high
	input  wire logic                      link_clk,  // modem bit clock (x16 in async)
	input  wire sisf_pkg::sisf_cfg_type    cfg,       // static line settings
	input  wire logic                      tx_valid,  // character offered
	output logic                           tx_ready,  // buffer can take it
	input  wire logic [7:0]                tx_data,   // character to send
	output logic                           rx_valid,  // one cycle, character out
	output sisf_pkg::sisf_rx_char_type     rx_char,   // character and fault flag
	output logic                           rx_locked, // sync framing locked
	input  wire logic                      line_in,   // serial data from modem
	output logic                           line_out   // serial data to modem
);
	// =========================================================
	// system side: buffer and transmit handoff
	// =========================================================
	logic       fifo_valid, fifo_ready;
	logic [7:0] fifo_data;
	logic [7:0] hold_r, hold_nxt;
	logic       req_r, req_nxt;
	logic       ack_s1_r, ack_s2_r;
	logic       tx_ack_r, tx_ack_nxt;

	sisf_fifo #(.WIDTH(sisf_pkg::CHAR_W), .DEPTH(sisf_pkg::FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);

	// a new word goes out only once the link has taken the last one
	always_comb begin
		fifo_ready = (req_r == ack_s2_r);
		hold_nxt   = hold_r;
		req_nxt    = req_r;
		if (fifo_valid && fifo_ready) begin
			hold_nxt = fifo_data;
			req_nxt  = ~req_r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_r   <= 8'h00;
			req_r    <= 1'h0;
			ack_s1_r <= 1'h0;
			ack_s2_r <= 1'h0;
		end else begin
			hold_r   <= hold_nxt;
			req_r    <= req_nxt;
			ack_s1_r <= tx_ack_r;
			ack_s2_r <= ack_s1_r;
		end
	end

	// =========================================================
	// system side: receive capture
	// =========================================================
	logic                         rx_tog_r;
	logic                         rxt_s1_r, rxt_s2_r, rxt_s3_r;
	logic                         lock_s1_r, lock_s2_r, lock_r;
	sisf_pkg::sisf_rx_char_type   rx_word_r;
	sisf_pkg::sisf_rx_char_type   rx_char_r, rx_char_nxt;
	logic                         rx_valid_r, rx_valid_nxt;

	always_comb begin
		rx_valid_nxt = (rxt_s2_r != rxt_s3_r);
		rx_char_nxt  = rx_valid_nxt ? rx_word_r : rx_char_r;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxt_s1_r   <= 1'h0;
			rxt_s2_r   <= 1'h0;
			rxt_s3_r   <= 1'h0;
			lock_s1_r  <= 1'h0;
			lock_s2_r  <= 1'h0;
			rx_char_r  <= '0;
			rx_valid_r <= 1'h0;
		end else begin
			rxt_s1_r   <= rx_tog_r;
			rxt_s2_r   <= rxt_s1_r;
			rxt_s3_r   <= rxt_s2_r;
			lock_s1_r  <= lock_r;
			lock_s2_r  <= lock_s1_r;
			rx_char_r  <= rx_char_nxt;
			rx_valid_r <= rx_valid_nxt;
		end
	end

	assign rx_valid  = rx_valid_r;
	assign rx_char   = rx_char_r;
	assign rx_locked = lock_s2_r;

	// =========================================================
	// link side: reset release, settings and line synchronisers
	// =========================================================
	logic                   lrst_s1_r, lrst_r;
	sisf_pkg::sisf_cfg_type cfg_s1_r, lcfg_r;
	logic                   req_s1_r, req_s2_r;
	logic                   lin_s1_r, lin_r;
	logic [3:0]             len_bits, nbits;
	logic [7:0]             len_mask;
	logic                   is_async, is_sync;

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lrst_s1_r <= 1'h1;
			lrst_r    <= 1'h1;
			cfg_s1_r  <= '0;
			lcfg_r    <= '0;
			req_s1_r  <= 1'h0;
			req_s2_r  <= 1'h0;
		end else begin
			lrst_s1_r <= 1'h0;
			lrst_r    <= lrst_s1_r;
			cfg_s1_r  <= cfg;
			lcfg_r    <= cfg_s1_r;
			req_s1_r  <= req_r;
			req_s2_r  <= req_s1_r;
		end
	end

	always_ff @(negedge link_clk or posedge lrst_r) begin
		if (lrst_r) begin
			lin_s1_r <= sisf_pkg::LINE_MARK;
			lin_r    <= sisf_pkg::LINE_MARK;
		end else begin
			lin_s1_r <= line_in;
			lin_r    <= lin_s1_r;
		end
	end

	always_comb begin
		len_bits = sisf_pkg::LEN_BASE + {2'h0, lcfg_r.len_code};
		nbits    = len_bits + {3'h0, lcfg_r.par_en};
		len_mask = sisf_pkg::MASK_FULL >> (4'h8 - len_bits);
		is_async = (lcfg_r.mode == sisf_pkg::MODE_ASYNC);
		is_sync  = (lcfg_r.mode == sisf_pkg::MODE_SYNC);
	end

	function automatic logic par_bit(input logic [7:0] d, input logic odd);
		par_bit = (^d) ^ odd;
	endfunction : par_bit

	// =========================================================
	// link side: transmitter, rising edge
	// =========================================================
	sisf_pkg::sisf_tx_state_type tx_st_r, tx_st_nxt;
	logic [8:0]                  tx_sh_r, tx_sh_nxt;
	logic [3:0]                  tx_bit_r, tx_bit_nxt;
	logic [4:0]                  tx_sub_r, tx_sub_nxt;
	logic [1:0]                  lead_r, lead_nxt;
	logic                        line_r, line_nxt;
	logic                        avail;
	logic                        fill;
	logic [4:0]                  bit_last, stop_last;
	logic [7:0]                  tx_word;
	logic [8:0]                  frame;

	always_comb begin
		avail     = (req_s2_r != tx_ack_r);
		fill      = is_sync && !(avail && lead_r == sisf_pkg::SYNC_LEAD);
		tx_word   = (fill ? lcfg_r.sync_char : hold_r) & len_mask;
		frame     = {1'h0, tx_word};
		frame[len_bits] = lcfg_r.par_en ? par_bit(tx_word, lcfg_r.par_odd) : 1'h0;
		bit_last  = is_async ? sisf_pkg::ASYNC_LAST : 5'h00;
		unique case (lcfg_r.stop)
			sisf_pkg::STOP_ONE:    stop_last = is_async ? sisf_pkg::STOP1_LAST
				: sisf_pkg::ISO_STOP1_LAST;
			sisf_pkg::STOP_ONE_42: stop_last = is_async ? sisf_pkg::STOP142_LAST
				: sisf_pkg::ISO_STOP2_LAST;
			default:               stop_last = is_async ? sisf_pkg::STOP2_LAST
				: sisf_pkg::ISO_STOP2_LAST;
		endcase
		tx_st_nxt  = tx_st_r;
		tx_sh_nxt  = tx_sh_r;
		tx_bit_nxt = tx_bit_r;
		tx_sub_nxt = tx_sub_r + 5'h01;
		tx_ack_nxt = tx_ack_r;
		lead_nxt   = is_sync ? lead_r : 2'h0;
		line_nxt   = line_r;
		unique case (tx_st_r)
			sisf_pkg::TX_IDLE: begin
				tx_sub_nxt = 5'h00;
				line_nxt   = sisf_pkg::LINE_MARK;
				if (is_sync) begin
					tx_st_nxt  = sisf_pkg::TX_DATA;
					tx_sh_nxt  = frame;
					tx_bit_nxt = 4'h0;
					line_nxt   = frame[0];
					tx_ack_nxt = fill ? tx_ack_r : ~tx_ack_r;
					if (fill && lead_r != sisf_pkg::SYNC_LEAD) begin
						lead_nxt = lead_r + 2'h1;
					end
				end else if (avail) begin
					tx_st_nxt  = sisf_pkg::TX_START;
					tx_sh_nxt  = frame;
					line_nxt   = sisf_pkg::LINE_SPACE;
					tx_ack_nxt = ~tx_ack_r;
				end
			end
			sisf_pkg::TX_START: begin
				if (tx_sub_r == bit_last) begin
					tx_st_nxt  = sisf_pkg::TX_DATA;
					tx_sub_nxt = 5'h00;
					tx_bit_nxt = 4'h0;
					line_nxt   = tx_sh_r[0];
				end
			end
			sisf_pkg::TX_DATA: begin
				if (tx_sub_r == bit_last) begin
					tx_sub_nxt = 5'h00;
					if (tx_bit_r == nbits - 4'h1) begin
						if (is_sync) begin
							tx_sh_nxt  = frame;
							tx_bit_nxt = 4'h0;
							line_nxt   = frame[0];
							tx_ack_nxt = fill ? tx_ack_r : ~tx_ack_r;
							if (fill && lead_r != sisf_pkg::SYNC_LEAD) begin
								lead_nxt = lead_r + 2'h1;
							end
						end else begin
							tx_st_nxt = sisf_pkg::TX_STOP;
							line_nxt  = sisf_pkg::LINE_MARK;
						end
					end else begin
						tx_sh_nxt  = tx_sh_r >> 1;
						tx_bit_nxt = tx_bit_r + 4'h1;
						line_nxt   = tx_sh_r[1];
					end
				end
			end
			sisf_pkg::TX_STOP: begin
				if (tx_sub_r == stop_last) begin
					tx_sub_nxt = 5'h00;
					if (avail && !is_sync) begin
						tx_st_nxt  = sisf_pkg::TX_START;
						tx_sh_nxt  = frame;
						line_nxt   = sisf_pkg::LINE_SPACE;
						tx_ack_nxt = ~tx_ack_r;
					end else begin
						tx_st_nxt = sisf_pkg::TX_IDLE;
					end
				end
			end
		endcase
		if (!is_sync && tx_st_r == sisf_pkg::TX_DATA && lead_r != 2'h0) begin
			tx_st_nxt = sisf_pkg::TX_IDLE;
			line_nxt  = sisf_pkg::LINE_MARK;
		end
	end

	always_ff @(posedge link_clk or posedge lrst_r) begin
		if (lrst_r) begin
			tx_st_r  <= sisf_pkg::TX_IDLE;
			tx_sh_r  <= 9'h000;
			tx_bit_r <= 4'h0;
			tx_sub_r <= 5'h00;
			tx_ack_r <= 1'h0;
			lead_r   <= 2'h0;
			line_r   <= sisf_pkg::LINE_MARK;
		end else begin
			tx_st_r  <= tx_st_nxt;
			tx_sh_r  <= tx_sh_nxt;
			tx_bit_r <= tx_bit_nxt;
			tx_sub_r <= tx_sub_nxt;
			tx_ack_r <= tx_ack_nxt;
			lead_r   <= lead_nxt;
			line_r   <= line_nxt;
		end
	end

	assign line_out = line_r;

	// =========================================================
	// link side: receiver, falling edge
	// =========================================================
	sisf_pkg::sisf_rx_state_type rx_st_r, rx_st_nxt;
	logic [8:0]                  rx_sh_r, rx_sh_nxt;
	logic [3:0]                  rx_bit_r, rx_bit_nxt;
	logic [4:0]                  rx_sub_r, rx_sub_nxt;
	logic                        rx_tog_nxt, lock_nxt;
	sisf_pkg::sisf_rx_char_type  rx_word_nxt;
	logic [8:0]                  shifted, aligned;
	logic                        sample, par_err;

	always_comb begin
		shifted     = {lin_r, rx_sh_r[8:1]};
		aligned     = shifted >> (4'h9 - nbits);
		par_err     = lcfg_r.par_en &&
			(aligned[len_bits] != par_bit(aligned[7:0] & len_mask, lcfg_r.par_odd));
		sample      = !is_async || (rx_sub_r == sisf_pkg::ASYNC_LAST);
		rx_st_nxt   = rx_st_r;
		rx_sh_nxt   = rx_sh_r;
		rx_bit_nxt  = rx_bit_r;
		rx_sub_nxt  = rx_sub_r + 5'h01;
		rx_tog_nxt  = rx_tog_r;
		rx_word_nxt = rx_word_r;
		lock_nxt    = 1'h0;
		unique case (rx_st_r)
			sisf_pkg::RX_IDLE: begin
				rx_sub_nxt = 5'h00;
				rx_bit_nxt = 4'h0;
				if (lin_r == sisf_pkg::LINE_SPACE) begin
					rx_st_nxt = is_async ? sisf_pkg::RX_START : sisf_pkg::RX_DATA;
				end
			end
			sisf_pkg::RX_START: begin
				if (rx_sub_r == sisf_pkg::START_MID) begin
					rx_sub_nxt = 5'h00;
					rx_st_nxt  = (lin_r == sisf_pkg::LINE_SPACE) ? sisf_pkg::RX_DATA
						: sisf_pkg::RX_IDLE;
				end
			end
			sisf_pkg::RX_DATA: begin
				if (sample) begin
					rx_sub_nxt = 5'h00;
					rx_sh_nxt  = shifted;
					rx_bit_nxt = rx_bit_r + 4'h1;
					if (rx_bit_r == nbits - 4'h1) begin
						rx_sh_nxt = aligned;
						rx_st_nxt = sisf_pkg::RX_STOP;
					end
				end
			end
			sisf_pkg::RX_STOP: begin
				if (sample) begin
					rx_word_nxt.data = rx_sh_r[7:0] & len_mask;
					rx_word_nxt.err  = (lin_r != sisf_pkg::LINE_MARK) ||
						(lcfg_r.par_en && rx_sh_r[len_bits] !=
						par_bit(rx_sh_r[7:0] & len_mask, lcfg_r.par_odd));
					rx_tog_nxt = ~rx_tog_r;
					rx_st_nxt  = sisf_pkg::RX_IDLE;
				end
			end
			sisf_pkg::RX_HUNT: begin
				rx_sh_nxt  = shifted;
				rx_bit_nxt = 4'h0;
				if (((shifted >> (4'h9 - len_bits)) & {1'h0, len_mask}) ==
					{1'h0, lcfg_r.sync_char & len_mask}) begin
					rx_st_nxt = sisf_pkg::RX_LOCK;
					lock_nxt  = 1'h1;
				end
			end
			sisf_pkg::RX_LOCK: begin
				lock_nxt   = 1'h1;
				rx_sh_nxt  = shifted;
				rx_bit_nxt = rx_bit_r + 4'h1;
				if (rx_bit_r == nbits - 4'h1) begin
					rx_bit_nxt       = 4'h0;
					rx_word_nxt.data = aligned[7:0] & len_mask;
					rx_word_nxt.err  = par_err;
					rx_tog_nxt       = ~rx_tog_r;
				end
			end
		endcase
		if (is_sync != (rx_st_r == sisf_pkg::RX_HUNT || rx_st_r == sisf_pkg::RX_LOCK)) begin
			rx_st_nxt = is_sync ? sisf_pkg::RX_HUNT : sisf_pkg::RX_IDLE;
			lock_nxt  = 1'h0;
		end
	end

	always_ff @(negedge link_clk or posedge lrst_r) begin
		if (lrst_r) begin
			rx_st_r   <= sisf_pkg::RX_IDLE;
			rx_sh_r   <= 9'h000;
			rx_bit_r  <= 4'h0;
			rx_sub_r  <= 5'h00;
			rx_tog_r  <= 1'h0;
			rx_word_r <= '0;
			lock_r    <= 1'h0;
		end else begin
			rx_st_r   <= rx_st_nxt;
			rx_sh_r   <= rx_sh_nxt;
			rx_bit_r  <= rx_bit_nxt;
			rx_sub_r  <= rx_sub_nxt;
			rx_tog_r  <= rx_tog_nxt;
			rx_word_r <= rx_word_nxt;
			lock_r    <= lock_nxt;
		end
	end

endmodule : sisf_framer

// >>> verif/sisf_modem.sv
// modem model: free running bit clock and a loopback return line
`timescale 1ns/1ps
module sisf_modem #(
	parameter real HALF_NS = 32.0
) (
	output logic      link_clk, // bit clock shared by both directions
	input  wire logic line_tx,  // serial data from the framer
	input  wire logic corrupt,  // hold the return line at space
	output logic      line_rx   // serial data to the framer
);
	// =========================================================
	// timing and line
	// =========================================================
	// sync modems keep timing running; phase offset keeps it apart from clk
	initial begin
		link_clk = 1'h0;
		#7.0;
		forever #(HALF_NS) link_clk = ~link_clk;
	end

	// data changes on rising edges, so it is settled at the falling edge
	assign line_rx = corrupt ? sisf_pkg::LINE_SPACE : line_tx;
endmodule : sisf_modem

// >>> verif/sisf_framer_props.sv
// concurrent checks on the serial line framer ports
`timescale 1ns/1ps
module sisf_framer_props (
	input wire logic                       clk,       // system clock
	input wire logic                       rst,       // async reset
	input wire logic                       link_clk,  // modem bit clock
	input wire sisf_pkg::sisf_cfg_type     cfg,       // line settings
	input wire logic                       tx_valid,  // character offered
	input wire logic                       tx_ready,  // buffer space
	input wire logic [7:0]                 tx_data,   // character
	input wire logic                       rx_valid,  // character out
	input wire sisf_pkg::sisf_rx_char_type rx_char,   // received character
	input wire logic                       rx_locked, // sync lock
	input wire logic                       line_in,   // serial in
	input wire logic                       line_out   // serial out
);
	// =========================================================
	// helpers
	// =========================================================
	logic [4:0]  run_r;
	logic [4:0]  run_nxt;
	logic        prev_lo_r;
	logic        lo_neg_r;
	logic [3:0]  nosync_r;
	logic [3:0]  nosync_nxt;
	logic [10:0] idle_r;
	logic [10:0] idle_nxt;

	// ticks the previous line level was held, and clk cycles since events
	always_comb begin
		run_nxt    = (line_out != prev_lo_r) ? 5'h01 : run_r + {4'h0, run_r != 5'h1F};
		nosync_nxt = (cfg.mode == sisf_pkg::MODE_SYNC) ? 4'h0 : nosync_r + {3'h0, nosync_r != 4'hF};
		idle_nxt   = (tx_valid && tx_ready) ? 11'h000 : idle_r + {10'h000, idle_r != 11'h7FF};
	end
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			run_r     <= 5'h1F;
			prev_lo_r <= 1'h1;
		end else begin
			run_r     <= run_nxt;
			prev_lo_r <= line_out;
		end
	end
	always_ff @(negedge link_clk or posedge rst) begin
		if (rst) lo_neg_r <= 1'h1;
		else lo_neg_r <= line_out;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nosync_r <= 4'h0;
			idle_r   <= 11'h000;
		end else begin
			nosync_r <= nosync_nxt;
			idle_r   <= idle_nxt;
		end
	end

	// =========================================================
	// properties
	// =========================================================
	property p_rx_pulse;
		@(posedge clk) disable iff (rst) rx_valid |=> !rx_valid;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("rx_valid held too long");
	property p_rx_hold;
		@(posedge clk) disable iff (rst) !rx_valid |-> $stable(rx_char);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx_char moved without rx_valid");
	property p_sync_quiet;
		@(posedge clk) disable iff (rst)
			(cfg.mode == sisf_pkg::MODE_SYNC && !rx_locked) |-> !rx_valid;
	endproperty
	a_sync_quiet: assert property (p_sync_quiet) else $error("character before lock");
	property p_len_mask;
		@(posedge clk) disable iff (rst)
			rx_valid |-> (rx_char.data >> ({2'h0, cfg.len_code} + 4'h5)) == 8'h00;
	endproperty
	a_len_mask: assert property (p_len_mask) else $error("bits above length set");
	property p_async_bit;
		@(posedge link_clk) disable iff (rst)
			(cfg.mode == sisf_pkg::MODE_ASYNC && line_out != prev_lo_r) |-> run_r >= 5'h10;
	endproperty
	a_async_bit: assert property (p_async_bit) else $error("async bit shorter than 16 ticks");
	property p_tx_edge;
		@(posedge link_clk) disable iff (rst) line_out == lo_neg_r;
	endproperty
	a_tx_edge: assert property (p_tx_edge) else $error("line_out moved on falling edge");
	property p_lock_mode;
		@(posedge clk) disable iff (rst) nosync_r == 4'hF |-> !rx_locked;
	endproperty
	a_lock_mode: assert property (p_lock_mode) else $error("lock outside sync mode");
	property p_tx_idle;
		@(posedge clk) disable iff (rst)
			(cfg.mode != sisf_pkg::MODE_SYNC && idle_r >= 11'h4B0) |-> line_out == sisf_pkg::LINE_MARK;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("line busy with nothing to send");

	c_good: cover property (@(posedge clk) disable iff (rst) rx_valid && !rx_char.err);
	c_bad: cover property (@(posedge clk) disable iff (rst) rx_valid && rx_char.err);
	c_lock: cover property (@(posedge clk) disable iff (rst) $rose(rx_locked));
endmodule : sisf_framer_props

bind sisf_framer sisf_framer_props i_sisf_framer_props (.clk(clk), .rst(rst),
	.link_clk(link_clk), .cfg(cfg), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.tx_data(tx_data), .rx_valid(rx_valid), .rx_char(rx_char), .rx_locked(rx_locked),
	.line_in(line_in), .line_out(line_out));

// >>> verif/tb_top.sv
// self-checking bench for the serial line framer, looped through the modem model
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		sisf_pkg::sisf_mode_type mode;
		logic [1:0]              len;
		sisf_pkg::sisf_stop_type stop;
		logic                    par;
		logic                    odd;
		logic [7:0]              data;
	} sisf_row_type;

	logic clk = 1'h0;
	logic rst, link_clk, tx_valid, tx_ready, rx_valid, rx_locked, line_in, line_out, corrupt;
	logic [7:0]                 tx_data;
	sisf_pkg::sisf_cfg_type     cfg;
	sisf_pkg::sisf_rx_char_type rx_char;
	sisf_pkg::sisf_rx_char_type c;
	sisf_pkg::sisf_rx_char_type rxq[$];
	sisf_row_type               rows[6];
	int                         n_fail, check_count, i, n;
	logic                       found;

	always #50 clk = ~clk;

	sisf_framer i_sisf_framer (.clk(clk), .rst(rst), .link_clk(link_clk), .cfg(cfg),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
		.rx_char(rx_char), .rx_locked(rx_locked), .line_in(line_in), .line_out(line_out));
	sisf_modem i_sisf_modem (.link_clk(link_clk), .line_tx(line_out), .corrupt(corrupt),
		.line_rx(line_in));

	// taken mid cycle, where the registered outputs have settled
	always @(negedge clk) if (rx_valid === 1'h1) rxq.push_back(rx_char);

	// =========================================================
	// tasks
	// =========================================================
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test

	task automatic give_up;
		n_fail++;
		$display("BAD at %0t wait ran out got %h exp %h", $time, 1'h0, 1'h1);
		finish_test();
	endtask : give_up

	task automatic put(input logic [7:0] d);
		logic ok;
		ok       = 1'h0;
		tx_data  = d;
		tx_valid = 1'h1;
		for (int w = 0; w < 200 && !ok; w++) begin
			ok = (tx_ready === 1'h1);
			step(1);
		end
		tx_valid = 1'h0;
		if (!ok) give_up();
	endtask : put

	// samples the frame at mid bit and checks start, data order, parity, stop
	task automatic watch(input sisf_row_type r);
		int         bt, nb;
		logic       seen;
		logic [8:0] bits, e;
		bt   = (r.mode == sisf_pkg::MODE_ASYNC) ? 16 : 1;
		nb   = 5 + r.len + r.par;
		bits = 9'h000;
		e    = {1'h0, r.data & (sisf_pkg::MASK_FULL >> (2'h3 - r.len))};
		if (r.par) e[nb - 1] = (^e) ^ r.odd;
		seen = 1'h0;
		for (int w = 0; w < 400 && !seen; w++) begin
			@(negedge link_clk);
			seen = (line_out === sisf_pkg::LINE_SPACE);
		end
		if (!seen) give_up();
		repeat (bt / 2) @(negedge link_clk);
		chk({8'h00, line_out}, 9'h000);
		for (int b = 0; b < nb; b++) begin
			repeat (bt) @(negedge link_clk);
			bits[b] = line_out;
		end
		chk(bits, e);
		repeat (bt) @(negedge link_clk);
		chk({8'h00, line_out}, 9'h001);
	endtask : watch

	task automatic take(input logic [8:0] exp);
		for (int w = 0; w < 300 && rxq.size() == 0; w++) @(posedge clk);
		if (rxq.size() == 0) give_up();
		chk(rxq.pop_front(), exp);
	endtask : take

	task automatic run_row(input sisf_row_type r);
		cfg = '{r.mode, r.len, r.stop, r.par, r.odd, 8'h16};
		step(20);
		// drop characters left over from the previous mode's line traffic
		rxq.delete();
		fork
			put(r.data);
			watch(r);
		join
		take({r.data & (sisf_pkg::MASK_FULL >> (2'h3 - r.len)), 1'h0});
		step(20);
	endtask : run_row

	// =========================================================
	// sequence
	// =========================================================
	initial begin
		rst = 1'h1;
		tx_valid = 1'h0;
		tx_data = 8'h00;
		corrupt = 1'h0;
		cfg = '0;
		n_fail = 0;
		check_count = 0;
		rows[0] = '{sisf_pkg::MODE_ASYNC, 2'h3, sisf_pkg::STOP_ONE, 1'h0, 1'h0, 8'hA5};
		rows[1] = '{sisf_pkg::MODE_ASYNC, 2'h0, sisf_pkg::STOP_ONE_42, 1'h1, 1'h0, 8'hF6};
		rows[2] = '{sisf_pkg::MODE_ASYNC, 2'h1, sisf_pkg::STOP_TWO, 1'h1, 1'h1, 8'h2B};
		rows[3] = '{sisf_pkg::MODE_ISO, 2'h2, sisf_pkg::STOP_ONE, 1'h0, 1'h0, 8'h5A};
		rows[4] = '{sisf_pkg::MODE_ISO, 2'h3, sisf_pkg::STOP_TWO, 1'h1, 1'h0, 8'hC3};
		rows[5] = '{sisf_pkg::MODE_ISO, 2'h0, sisf_pkg::STOP_ONE_42, 1'h1, 1'h1, 8'h1F};
		step(4);
		rst = 1'h0;
		step(4);
		for (i = 0; i < 6; i++) run_row(rows[i]);
		$display("test table done");
		// line held at space: stop sample fails
		cfg = '{sisf_pkg::MODE_ISO, 2'h3, sisf_pkg::STOP_ONE, 1'h0, 1'h0, 8'h16};
		step(20);
		corrupt = 1'h1;
		take({8'h00, 1'h1});
		corrupt = 1'h0;
		step(60);
		rxq.delete();
		$display("test frame fault done");
		// fill the buffer until it refuses, then drain through the line
		cfg = '{sisf_pkg::MODE_ASYNC, 2'h3, sisf_pkg::STOP_ONE, 1'h0, 1'h0, 8'h16};
		step(20);
		n = 0;
		tx_data = 8'h30;
		tx_valid = 1'h1;
		for (int w = 0; w < 16 && tx_ready === 1'h1; w++) begin
			step(1);
			n++;
			tx_data = 8'h30 + n[7:0];
		end
		tx_valid = 1'h0;
		chk({8'h00, n >= 8 && n <= 10}, 9'h001);
		for (int j = 0; j < n; j++) take({8'h30 + j[7:0], 1'h0});
		step(300);
		chk({8'h00, line_out}, 9'h001);
		$display("test buffer done");
		// sync: lock on leading pattern, then data among fill characters
		cfg = '{sisf_pkg::MODE_SYNC, 2'h3, sisf_pkg::STOP_ONE, 1'h0, 1'h0, 8'h16};
		for (int w = 0; w < 200 && rx_locked !== 1'h1; w++) step(1);
		chk({8'h00, rx_locked}, 9'h001);
		rxq.delete();
		put(8'h5A);
		found = 1'h0;
		c = '0;
		for (int w = 0; w < 300 && !found; w++) begin
			step(1);
			if (rxq.size() > 0) begin
				c = rxq.pop_front();
				found = (c.data !== 8'h16);
			end
		end
		chk(c, {8'h5A, 1'h0});
		step(40);
		chk({8'h00, rx_locked}, 9'h001);
		// lock must drop once the mode leaves sync, then return on the pattern
		cfg.mode = sisf_pkg::MODE_ISO;
		step(20);
		chk({8'h00, rx_locked}, 9'h000);
		cfg.mode = sisf_pkg::MODE_SYNC;
		for (int w = 0; w < 200 && rx_locked !== 1'h1; w++) step(1);
		chk({8'h00, rx_locked}, 9'h001);
		$display("test sync done");
		// reset in mid-run while locked
		rst = 1'h1;
		step(4);
		chk({tx_ready, rx_valid, rx_locked, line_out, 5'h00}, 9'h120);
		rst = 1'h0;
		step(4);
		rxq.delete();
		run_row(rows[3]);
		$display("test reset done");
		finish_test();
	end
endmodule : tb_top
